// ---- core/flash_cmd_if.sv ----
/*
  Interface carrying a taken programming command from the control block
  to the operation timer. Assumes one clock domain.
*/
`timescale 1ns/10ps
`default_nettype none
interface flash_cmd_if;
  logic start;
  logic [4:0] cmd;
  logic busy;
  logic done;
  modport ctrl (output start, output cmd, input busy, input done);
  modport timer (input start, input cmd, output busy, output done);
endinterface
`default_nettype wire

// ---- core/flash_op_timer.sv ----
/*
  Operation timer: counts out a page write, page erase or lock-bit write.
  Assumes start is a one-cycle pulse given only while not busy.
*/
`timescale 1ns/10ps
`default_nettype none
module flash_op_timer #(
  parameter int PROG_CYCLES = flash_self_prog_pkg::PROG_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst,
  flash_cmd_if.timer cmdIf
);
  logic [31:0] cnt_q, cnt_d;
  logic busy_q, busy_d;
  logic done_q, done_d;

  always_comb begin
    cnt_d = cnt_q;
    busy_d = busy_q;
    done_d = 1'b0;
    if (cmdIf.start && !busy_q) begin
      busy_d = 1'b1;
      cnt_d = 32'(PROG_CYCLES - 1);
    end else if (busy_q) begin
      if (cnt_q == 32'h0) begin
        busy_d = 1'b0;
        done_d = 1'b1;
      end else begin
        cnt_d = cnt_q - 32'h1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cnt_q <= 32'h0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      busy_q <= busy_d;
      done_q <= done_d;
    end
  end

  assign cmdIf.busy = busy_q;
  assign cmdIf.done = done_q;

  a_done_after_busy: assert property (@(posedge ref_clk) disable iff (rst)
    cmdIf.done |-> !busy_q && $past(busy_q)) else $error("done without busy");
  a_start_cmd_ok: assert property (@(posedge ref_clk) disable iff (rst)
    cmdIf.start |-> cmdIf.cmd == flash_self_prog_pkg::CMD_PGWR ||
      cmdIf.cmd == flash_self_prog_pkg::CMD_ERASE ||
      cmdIf.cmd == flash_self_prog_pkg::CMD_LOCKWR)
    else $error("start with bad command");
endmodule
`default_nettype wire

// ---- core/flash_self_prog_pkg.sv ----
/*
  Constants for the flash self-programming control block: control register
  layout, command patterns, register offsets and timing counts.
  Assumes a single 40 MHz system clock.
*/
package flash_self_prog_pkg;
  localparam int CLK_MHZ = 40;
  localparam int ADDR_W = 4;
  localparam logic [3:0] OFF_CTRL = 4'h0;
  localparam logic [3:0] OFF_LOCK = 4'h1;
  localparam logic [3:0] OFF_PTRL = 4'h2;
  localparam logic [3:0] OFF_PTRH = 4'h3;
  localparam logic [3:0] OFF_DLO = 4'h4;
  localparam logic [3:0] OFF_DHI = 4'h5;
  localparam logic [3:0] OFF_STAT = 4'h6;
  localparam int BIT_EN = 0;
  localparam int BIT_ERASE = 1;
  localparam int BIT_PGWR = 2;
  localparam int BIT_LOCKWR = 3;
  localparam int BIT_REEN = 4;
  localparam int BIT_BUSY = 6;
  localparam logic [4:0] CMD_LOAD = 5'h01;
  localparam logic [4:0] CMD_ERASE = 5'h03;
  localparam logic [4:0] CMD_PGWR = 5'h05;
  localparam logic [4:0] CMD_LOCKWR = 5'h09;
  localparam logic [4:0] CMD_REEN = 5'h11;
  localparam logic [2:0] ARM_CYCLES = 3'h4;
  localparam int PROG_TIME_US = 2000;
  localparam int PROG_CYCLES = PROG_TIME_US * CLK_MHZ;
  localparam logic [5:0] LOCK_RESET = 6'h3f;
  localparam logic [7:0] STAT_RESET = 8'h00;
endpackage

// ---- core/flash_self_program_control.sv ----
/*
  Flash self-programming control: control register, timed command window,
  page buffer loads, page write, page erase, lock-bit write, section
  re-enable and boot-lock bits. Assumes the processor core raises spmExec
  for one cycle per store-to-program-memory instruction and obeys cpuStall.
*/
// Our own choices: the address map and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
module flash_self_program_control #(
  parameter int PROG_CYCLES = flash_self_prog_pkg::PROG_CYCLES,
  parameter int PAGE_WORDS = 64
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdata,
  input wire logic spmExec,
  input wire logic spmInBoot,
  input wire logic chipErase,
  output logic cpuStall,
  output logic bufWe,
  output logic [5:0] bufIndex,
  output logic [15:0] bufData,
  output logic flashWrite,
  output logic flashErase,
  output logic [6:0] pageAddr,
  output logic [5:0] lockBits
);
  flash_cmd_if cmdIf ();

  flash_op_timer #(.PROG_CYCLES(PROG_CYCLES)) u_timer (
    .ref_clk(ref_clk),
    .rst(rst),
    .cmdIf(cmdIf)
  );

  // ----------------------------------------
  // Register state
  // ----------------------------------------
  logic [7:0] ctrl_q, ctrl_d;
  logic [7:0] ptrLo_q, ptrLo_d;
  logic [7:0] ptrHi_q, ptrHi_d;
  logic [7:0] dLo_q, dLo_d;
  logic [7:0] dHi_q, dHi_d;
  logic [5:0] lock_q, lock_d;
  logic [2:0] arm_q, arm_d;
  logic [7:0] rdata_q, rdata_d;
  logic start_q, start_d;
  logic [4:0] cmd_q, cmd_d;
  logic stall_q, stall_d;
  logic bufWe_q, bufWe_d;
  logic [5:0] bufIdx_q, bufIdx_d;
  logic [15:0] bufData_q, bufData_d;
  logic fw_q, fw_d;
  logic fe_q, fe_d;
  logic [6:0] page_q, page_d;
  logic spmTaken;
  logic [13:0] ptr;

  assign ptr = {ptrHi_q[5:0], ptrLo_q};
  assign spmTaken = spmExec && (arm_q != 3'h0) && !cmdIf.busy;

  // Boot-loader section protection from the upper lock pair (BLB1x)
  function automatic logic bootProtected(input logic [5:0] lk);
    bootProtected = (lk[5:4] != 2'b11);
  endfunction

  function automatic logic appProtected(input logic [5:0] lk);
    appProtected = (lk[3:2] != 2'b11);
  endfunction

  function automatic logic [7:0] regValue(input logic [3:0] a);
    unique case (a)
      flash_self_prog_pkg::OFF_CTRL: regValue = ctrl_q;
      flash_self_prog_pkg::OFF_LOCK: regValue = {2'b00, lock_q};
      flash_self_prog_pkg::OFF_PTRL: regValue = ptrLo_q;
      flash_self_prog_pkg::OFF_PTRH: regValue = ptrHi_q;
      flash_self_prog_pkg::OFF_DLO: regValue = dLo_q;
      flash_self_prog_pkg::OFF_DHI: regValue = dHi_q;
      flash_self_prog_pkg::OFF_STAT: regValue = {7'h00, cmdIf.busy};
      default: regValue = 8'h00;
    endcase
  endfunction

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    logic prot;
    prot = 1'b0;
    ctrl_d = ctrl_q;
    ptrLo_d = ptrLo_q;
    ptrHi_d = ptrHi_q;
    dLo_d = dLo_q;
    dHi_d = dHi_q;
    lock_d = lock_q;
    arm_d = (arm_q != 3'h0) ? arm_q - 3'h1 : 3'h0;
    rdata_d = regRd ? regValue(regAddr) : 8'h00;
    start_d = 1'b0;
    cmd_d = cmd_q;
    bufWe_d = 1'b0;
    bufIdx_d = bufIdx_q;
    bufData_d = bufData_q;
    fw_d = 1'b0;
    fe_d = 1'b0;
    page_d = page_q;
    // Window closes after four cycles; the command lapses unused
    if (arm_q == 3'h1) begin
      ctrl_d[4:0] = 5'h00;
    end
    if (regWr) begin
      unique case (regAddr)
        flash_self_prog_pkg::OFF_CTRL: begin
          // Writes during an operation are dropped; the core is stalled anyway
          if (!cmdIf.busy) begin
            ctrl_d = {ctrl_q[7:5], regWdata[4:0]};
            arm_d = regWdata[flash_self_prog_pkg::BIT_EN] ?
                    flash_self_prog_pkg::ARM_CYCLES : 3'h0;
          end
        end
        flash_self_prog_pkg::OFF_PTRL: ptrLo_d = regWdata;
        flash_self_prog_pkg::OFF_PTRH: ptrHi_d = regWdata;
        flash_self_prog_pkg::OFF_DLO: dLo_d = regWdata;
        flash_self_prog_pkg::OFF_DHI: dHi_d = regWdata;
        default: ;
      endcase
    end
    if (spmTaken) begin
      arm_d = 3'h0;
      ctrl_d[4:0] = 5'h00;
      prot = spmInBoot ? bootProtected(lock_q) : appProtected(lock_q);
      unique case (ctrl_q[4:0])
        flash_self_prog_pkg::CMD_LOAD: begin
          bufWe_d = 1'b1;
          bufIdx_d = ptr[6:1];
          bufData_d = {dHi_q, dLo_q};
        end
        flash_self_prog_pkg::CMD_PGWR: begin
          // Operand registers play no part here
          if (!prot) begin
            fw_d = 1'b1;
            page_d = ptr[13:7];
            start_d = 1'b1;
            cmd_d = ctrl_q[4:0];
            ctrl_d[flash_self_prog_pkg::BIT_EN] = 1'b1;
            ctrl_d[flash_self_prog_pkg::BIT_PGWR] = 1'b1;
          end
        end
        flash_self_prog_pkg::CMD_ERASE: begin
          if (!prot) begin
            fe_d = 1'b1;
            page_d = ptr[13:7];
            start_d = 1'b1;
            cmd_d = ctrl_q[4:0];
            ctrl_d[1:0] = 2'b11;
          end
        end
        flash_self_prog_pkg::CMD_LOCKWR: begin
          // Programming only clears bits; both pairs written independently
          lock_d = lock_q & {dLo_q[5:2], 2'b11};
          start_d = 1'b1;
          cmd_d = ctrl_q[4:0];
          ctrl_d[flash_self_prog_pkg::BIT_EN] = 1'b1;
          ctrl_d[flash_self_prog_pkg::BIT_LOCKWR] = 1'b1;
        end
        flash_self_prog_pkg::CMD_REEN: begin
          // Section is never busy here; command accepted with no effect
          ctrl_d[flash_self_prog_pkg::BIT_BUSY] = 1'b0;
        end
        default: ;
      endcase
    end
    if (cmdIf.done) begin
      ctrl_d[3:0] = 4'h0;
    end
    if (chipErase) begin
      lock_d = flash_self_prog_pkg::LOCK_RESET;
    end
    // Bridge the cycle between the start pulse and the timer's busy flag
    stall_d = start_d || cmdIf.start || (cmdIf.busy && !cmdIf.done);
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctrl_q <= flash_self_prog_pkg::STAT_RESET;
      ptrLo_q <= 8'h00;
      ptrHi_q <= 8'h00;
      dLo_q <= 8'h00;
      dHi_q <= 8'h00;
      lock_q <= flash_self_prog_pkg::LOCK_RESET;
      arm_q <= 3'h0;
      rdata_q <= 8'h00;
      start_q <= 1'b0;
      cmd_q <= 5'h00;
      stall_q <= 1'b0;
      bufWe_q <= 1'b0;
      bufIdx_q <= 6'h00;
      bufData_q <= 16'h0000;
      fw_q <= 1'b0;
      fe_q <= 1'b0;
      page_q <= 7'h00;
    end else begin
      ctrl_q <= ctrl_d;
      ptrLo_q <= ptrLo_d;
      ptrHi_q <= ptrHi_d;
      dLo_q <= dLo_d;
      dHi_q <= dHi_d;
      lock_q <= lock_d;
      arm_q <= arm_d;
      rdata_q <= rdata_d;
      start_q <= start_d;
      cmd_q <= cmd_d;
      stall_q <= stall_d;
      bufWe_q <= bufWe_d;
      bufIdx_q <= bufIdx_d;
      bufData_q <= bufData_d;
      fw_q <= fw_d;
      fe_q <= fe_d;
      page_q <= page_d;
    end
  end

  assign cmdIf.start = start_q;
  assign cmdIf.cmd = cmd_q;
  assign regRdata = rdata_q;
  assign cpuStall = stall_q;
  assign bufWe = bufWe_q;
  assign bufIndex = bufIdx_q;
  assign bufData = bufData_q;
  assign flashWrite = fw_q;
  assign flashErase = fe_q;
  assign pageAddr = page_q;
  assign lockBits = lock_q;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_pgwr_window: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(fw_q) |-> $past(arm_q) != 3'h0 && $past(ctrl_q[4:0]) == 5'h05)
    else $error("page write outside window");
  a_late_lapse: assert property (@(posedge ref_clk) disable iff (rst)
    spmExec && arm_q == 3'h0 |=> !start_q && !bufWe_q && !fw_q)
    else $error("late store took effect");
  a_page_field: assert property (@(posedge ref_clk) disable iff (rst)
    fw_q |-> pageAddr == $past(ptr[13:7])) else $error("wrong page");
  a_stall_busy: assert property (@(posedge ref_clk) disable iff (rst)
    start_q |-> cpuStall ##1 cpuStall) else $error("no stall");
  a_enable_clears: assert property (@(posedge ref_clk) disable iff (rst)
    cmdIf.done |=> !ctrl_q[0]) else $error("enable stuck");
  a_lock_sticky: assert property (@(posedge ref_clk) disable iff (rst)
    !$past(chipErase) |-> (lock_q & ~$past(lock_q)) == 6'h00)
    else $error("lock bit unprogrammed");
  a_unknown_ignored: assert property (@(posedge ref_clk) disable iff (rst)
    spmTaken && ctrl_q[4:0] == 5'h07 |=> !start_q && !bufWe_q && !fw_q)
    else $error("unknown command acted");
  a_busy_bit_zero: assert property (@(posedge ref_clk) disable iff (rst)
    !ctrl_q[6]) else $error("section busy set");
  a_pgwr_no_load: assert property (@(posedge ref_clk) disable iff (rst)
    spmTaken && ctrl_q[4:0] == flash_self_prog_pkg::CMD_PGWR |=> !bufWe_q)
    else $error("page write touched buffer");
  a_erase_page: assert property (@(posedge ref_clk) disable iff (rst)
    fe_q |-> pageAddr == $past(ptr[13:7])) else $error("wrong erase page");

  // ----------------------------------------
  // Protection checks
  // ----------------------------------------
  a_app_lock_blocks: assert property (@(posedge ref_clk) disable iff (rst)
    spmTaken && !spmInBoot && lock_q[3:2] != 2'b11 |=> !fw_q && !fe_q)
    else $error("protected application section changed");
  a_boot_lock_blocks: assert property (@(posedge ref_clk) disable iff (rst)
    spmTaken && spmInBoot && lock_q[5:4] != 2'b11 |=> !fw_q && !fe_q)
    else $error("protected boot section changed");
  a_erase_unlocks: assert property (@(posedge ref_clk) disable iff (rst)
    chipErase |=> lockBits == flash_self_prog_pkg::LOCK_RESET)
    else $error("chip erase kept lock bits");
endmodule
`default_nettype wire

// ---- tb/cpu_core_model.sv ----
/*
  Processor core model running boot-loader code: drives the register
  port and the store pulse. Assumes one clock and a one-cycle read answer.
*/
`timescale 1ns/10ps
`default_nettype none
module cpu_core_model (
  input wire logic ref_clk,
  input wire logic cpuStall,
  input wire logic [7:0] regRdata,
  output logic [3:0] regAddr,
  output logic [7:0] regWdata,
  output logic regWr,
  output logic regRd,
  output logic spmExec,
  output logic spmInBoot
);
  // ----------
  // Idle levels
  // ----------
  initial begin
    regAddr = 4'h0;
    regWdata = 8'h00;
    regWr = 1'b0;
    regRd = 1'b0;
    spmExec = 1'b0;
    spmInBoot = 1'b1;
  end
  // ----------
  // Bus cycles
  // ----------
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge ref_clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge ref_clk);
    regRd <= 1'b0;
    #1 d = regRdata;
    @(posedge ref_clk);
  endtask
  task automatic set_boot(input logic b);
    spmInBoot <= b;
  endtask
  // Interrupts never intrude, so the gap is exactly as asked
  task automatic spm(input logic [4:0] c, input int gap);
    int n;
    n = 0;
    // No EEPROM write runs here, so the idle wait before it is empty
    wr(flash_self_prog_pkg::OFF_CTRL, {3'h0, c});
    repeat (gap - 1) @(posedge ref_clk);
    spmExec <= 1'b1;
    @(posedge ref_clk);
    // Filler word and no-op: the bus stays quiet after the store
    spmExec <= 1'b0;
    @(posedge ref_clk);
    #1;
    while (cpuStall === 1'b1 && n < 200) begin
      @(posedge ref_clk);
      #1 n++;
    end
    @(posedge ref_clk);
  endtask
endmodule
`default_nettype wire

// ---- tb/test_flash_self_program_control.sv ----
/*
  Self-checking bench for the flash self-programming control block.
  Assumes the core model above and a shortened operation time.
*/
`timescale 1ns/10ps
`default_nettype none
module test_flash_self_program_control;
  localparam int PROG = 8;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic chipErase = 1'b0;
  logic [3:0] regAddr;
  logic [7:0] regWdata, regRdata;
  logic regWr, regRd, spmExec, spmInBoot, cpuStall, bufWe, flashWrite, flashErase;
  logic [5:0] bufIndex, lockBits, lastIdx;
  logic [15:0] bufData, lastData;
  logic [6:0] pageAddr;
  int fails = 0;
  int samples_checked = 0;
  int cycles = 0, wrCnt = 0, ersCnt = 0, bufCnt = 0, stallCnt = 0;
  always #12.5 ref_clk = ~ref_clk;
  cpu_core_model cpu_core_model_inst (.ref_clk(ref_clk), .cpuStall(cpuStall),
    .regRdata(regRdata), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .spmExec(spmExec), .spmInBoot(spmInBoot));
  flash_self_program_control #(.PROG_CYCLES(PROG)) flash_self_program_control_inst (
    .ref_clk(ref_clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .spmExec(spmExec),
    .spmInBoot(spmInBoot), .chipErase(chipErase), .cpuStall(cpuStall),
    .bufWe(bufWe), .bufIndex(bufIndex), .bufData(bufData), .flashWrite(flashWrite),
    .flashErase(flashErase), .pageAddr(pageAddr), .lockBits(lockBits));
  // ----------
  // Pulse monitor and hang guard
  // ----------
  always @(posedge ref_clk) begin
    cycles++;
    if (flashWrite === 1'b1) wrCnt++;
    if (flashErase === 1'b1) ersCnt++;
    if (cpuStall === 1'b1) stallCnt++;
    if (bufWe === 1'b1) begin
      bufCnt++;
      lastIdx = bufIndex;
      lastData = bufData;
    end
    if (cycles == 5000) begin
      fails++;
      $display("ERROR %0t run did not finish", $time);
      summarize();
    end
  end
  // ----------
  // Checking helpers
  // ----------
  task automatic summarize();
    $display("Checks %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rdchk(input logic [3:0] a, input logic [15:0] exp);
    logic [7:0] d;
    cpu_core_model_inst.rd(a, d);
    chk({8'h00, d}, exp);
  endtask
  task automatic setreg(input logic [3:0] a, input logic [7:0] d);
    cpu_core_model_inst.wr(a, d);
  endtask
  // ----------
  // Scenarios
  // ----------
  task automatic t_reset();
    chk({10'h000, lockBits}, 16'h003f);
    rdchk(flash_self_prog_pkg::OFF_CTRL, 16'h0000);
    rdchk(flash_self_prog_pkg::OFF_STAT, 16'h0000);
    rdchk(4'h7, 16'h0000);
  endtask
  task automatic t_load();
    int n;
    n = bufCnt;
    setreg(flash_self_prog_pkg::OFF_PTRL, 8'h86);
    setreg(flash_self_prog_pkg::OFF_PTRH, 8'h00);
    setreg(flash_self_prog_pkg::OFF_DLO, 8'h34);
    setreg(flash_self_prog_pkg::OFF_DHI, 8'h12);
    cpu_core_model_inst.spm(flash_self_prog_pkg::CMD_LOAD, 1);
    chk(16'(bufCnt - n), 16'h0001);
    chk({10'h000, lastIdx}, 16'h0003);
    chk(lastData, 16'h1234);
  endtask
  // Latest legal store, page 0x55 with zero offset
  task automatic t_page_write();
    int b, w, s;
    b = bufCnt;
    w = wrCnt;
    s = stallCnt;
    setreg(flash_self_prog_pkg::OFF_PTRL, 8'h80);
    setreg(flash_self_prog_pkg::OFF_PTRH, 8'h2a);
    cpu_core_model_inst.spm(flash_self_prog_pkg::CMD_PGWR, 4);
    chk(16'(wrCnt - w), 16'h0001);
    chk({9'h000, pageAddr}, 16'h0055);
    chk(16'(bufCnt - b), 16'h0000);
    chk(16'((stallCnt - s) >= PROG), 16'h0001);
    rdchk(flash_self_prog_pkg::OFF_CTRL, 16'h0000);
  endtask
  task automatic t_lapse_unknown();
    logic [4:0] codes [3] = '{5'h05, 5'h07, 5'h15};
    int w, s;
    for (int i = 0; i < 3; i++) begin
      w = wrCnt;
      s = stallCnt + ersCnt + bufCnt;
      cpu_core_model_inst.spm(codes[i], (i == 0) ? 5 : 1);
      chk(16'(wrCnt - w), 16'h0000);
      chk(16'(stallCnt + ersCnt + bufCnt - s), 16'h0000);
      chk({10'h000, lockBits}, 16'h003f);
    end
  endtask
  task automatic t_erase();
    int e, s;
    e = ersCnt;
    s = stallCnt;
    cpu_core_model_inst.spm(flash_self_prog_pkg::CMD_ERASE, 2);
    chk(16'(ersCnt - e), 16'h0001);
    chk(16'((stallCnt - s) >= PROG), 16'h0001);
  endtask
  // Page write attempt from one section against the current lock bits
  task automatic t_guard(input logic inBoot, input int exp);
    int w;
    w = wrCnt;
    cpu_core_model_inst.set_boot(inBoot);
    cpu_core_model_inst.spm(flash_self_prog_pkg::CMD_PGWR, 1);
    chk(16'(wrCnt - w), 16'(exp));
  endtask
  // App pair, then boot pair, then an attempt to unprogram
  task automatic t_lock();
    logic [7:0] ops [3] = '{8'hf3, 8'hcf, 8'hff};
    logic [5:0] exp [3] = '{6'h33, 6'h03, 6'h03};
    for (int i = 0; i < 3; i++) begin
      setreg(flash_self_prog_pkg::OFF_DLO, ops[i]);
      cpu_core_model_inst.spm(flash_self_prog_pkg::CMD_LOCKWR, 3);
      chk({10'h000, lockBits}, {10'h000, exp[i]});
      if (i == 0) begin
        t_guard(1'b0, 0);
        t_guard(1'b1, 1);
      end
    end
    t_guard(1'b1, 0);
    chipErase <= 1'b1;
    @(posedge ref_clk);
    chipErase <= 1'b0;
    repeat (2) @(posedge ref_clk);
    chk({10'h000, lockBits}, 16'h003f);
  endtask
  task automatic t_reenable();
    cpu_core_model_inst.spm(flash_self_prog_pkg::CMD_REEN, 1);
    rdchk(flash_self_prog_pkg::OFF_CTRL, 16'h0000);
  endtask
  initial begin
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    t_reset();
    t_load();
    t_page_write();
    t_lapse_unknown();
    t_erase();
    t_lock();
    t_reenable();
    summarize();
  end
endmodule
`default_nettype wire
